// ===== bench/boundary_scan_chain_bench.sv
// self-checking bench for the boundary scan chain cells
`timescale 1ns/1ps
module boundary_scan_chain_bench;
	localparam int NP  = 2;
	localparam int LEN = 18 + 3 * NP;
	// no output control with two-wire enable on a pin, one main clock, comparator optional
	localparam logic [LEN-1:0] LATCH_A = 24'h3a3410;
	localparam logic [LEN-1:0] LATCH_B = 24'hc54004;
	// rows: pull-up disable, output register, direction, expected pull-up
	localparam logic [6:0] ROWS [8] = '{7'h33, 7'h70, 7'h36, 7'h19, 7'h00, 7'h22, 7'h4c, 7'h3c};

	logic            mclk, rstn, tck, tdi, tdo, capture_dr, shift_dr, update_dr, extest_sel, sample_sel;
	logic            global_pullup_disable, normal_reset_n_pin, hv_program_reset;
	logic [NP-1:0]   pin_output_register, pin_direction_bit, pin_in, pin_out, pin_oe_n, pin_pullup_enable;
	logic [1:0]      two_wire_sys_enable, two_wire_driver_enable;
	logic [4:0]      clock_enable_sys, clock_line, clock_enable_out;
	logic            comparator_off_sys, comparator_mux_sys, comparator_bg_sys, comparator_result;
	logic            comparator_off, comparator_mux_select, comparator_bandgap_select, comparator_neg_from_mux;
	logic [16:0]     outs;
	int              compares;
	int              n_mismatch;

	assign outs = {comparator_neg_from_mux, comparator_bandgap_select, comparator_mux_select, comparator_off,
		clock_enable_out, two_wire_driver_enable, pin_pullup_enable, pin_oe_n, pin_out};

	boundary_scan_chain #(.N_PINS(NP)) boundary_scan_chain_inst (.mclk, .rstn, .tck, .tdi, .tdo, .capture_dr,
		.shift_dr, .update_dr, .extest_sel, .sample_sel, .global_pullup_disable, .pin_output_register,
		.pin_direction_bit, .pin_in, .pin_out, .pin_oe_n, .pin_pullup_enable, .two_wire_sys_enable,
		.two_wire_driver_enable, .normal_reset_n_pin, .hv_program_reset, .clock_enable_sys, .clock_line,
		.clock_enable_out, .comparator_off_sys, .comparator_mux_sys, .comparator_bg_sys, .comparator_result,
		.comparator_off, .comparator_mux_select, .comparator_bandgap_select, .comparator_neg_from_mux);

	scan_tester #(.LEN(LEN)) scan_tester_inst (.tdo, .tck, .tdi, .capture_dr, .shift_dr, .update_dr);

	initial
	begin
		mclk = 1'h0;
	end
	always #2.5 mclk = ~mclk;

	// ****************************************
	// helpers
	// ****************************************
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic report(input logic [31:0] got, input logic [31:0] want);
		compares++;
		if (got !== want)
		begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask

	task automatic check_out(input logic [16:0] got, input logic [16:0] want);
		report(32'(got), 32'(want));
	endtask

	task automatic check_chain(input logic [LEN-1:0] got, input logic [LEN-1:0] want);
		report(32'(got), 32'(want));
	endtask

	// pin side values that a latch word drives under external test
	function automatic logic [16:0] from_latch(input logic [LEN-1:0] v);
		return {v[13], v[14], v[13], v[12], v[10], v[8], v[6], v[4], v[2], v[17:16], v[21], v[18],
			~v[22], ~v[19], v[23], v[20]};
	endfunction

	task automatic tally_and_finish();
		$display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial
	begin
		#100us;
		n_mismatch++;
		tally_and_finish();
	end

	// ****************************************
	// tests
	// ****************************************
	initial
	begin
		logic [LEN-1:0] dout;
		logic [LEN-1:0] want;
		logic [6:0]     r;
		compares = 0;
		n_mismatch = 0;
		{rstn, extest_sel, sample_sel, global_pullup_disable, hv_program_reset, comparator_result} = 6'h00;
		{comparator_off_sys, comparator_mux_sys, comparator_bg_sys} = 3'h0;
		{pin_output_register, pin_direction_bit, pin_in, two_wire_sys_enable} = 8'h00;
		{clock_enable_sys, clock_line} = 10'h000;
		normal_reset_n_pin = 1'h1;
		tick(3);
		// pins released while in reset
		check_out(outs, 17'h0000c);
		check_chain(LEN'(tdo), '0);
		rstn = 1'h1;
		for (int i = 0; i < 8; i++)
		begin
			r = ROWS[i];
			global_pullup_disable = r[6];
			pin_output_register = r[5:4];
			pin_direction_bit = r[3:2];
			two_wire_sys_enable = r[5:4];
			clock_enable_sys = {r[3:2], r[5:4], r[6]};
			{comparator_off_sys, comparator_mux_sys, comparator_bg_sys} = {r[6], r[4], r[2]};
			tick(2);
			check_out(outs, {r[4], r[2], r[4], r[6], r[3:2], r[5:4], r[6], r[5:4], r[1:0], ~r[3:2], r[5:4]});
		end
		sample_sel = 1'h1;
		global_pullup_disable = 1'h0;
		{pin_output_register, pin_direction_bit, two_wire_sys_enable} = 6'h1a;
		clock_enable_sys = 5'h11;
		{comparator_off_sys, comparator_mux_sys, comparator_bg_sys} = 3'h5;
		for (int k = 0; k < 2; k++)
		begin
			clock_line = k ? 5'h00 : 5'h1f;
			{normal_reset_n_pin, hv_program_reset, comparator_result} = {~k[0], k[0], k[0]};
			pin_in = k ? 2'h1 : 2'h2;
			tick(4);
			want = '0;
			want[1:0] = {k[0], ~k[0]};
			for (int c = 0; c < 5; c++)
			begin
				want[2 + 2 * c] = clock_enable_sys[c];
				want[3 + 2 * c] = clock_enable_sys[c] ? clock_line[c] : scan_pkg::CLK_IDLE[c];
			end
			want[17:12] = {2'h2, k[0], 3'h5};
			for (int p = 0; p < NP; p++)
				want[18 + 3 * p +: 3] = {pin_in[p], pin_direction_bit[p],
					~global_pullup_disable & ~pin_direction_bit[p] & pin_output_register[p]};
			scan_tester_inst.scan(k ? LATCH_A : '0, dout);
			check_chain(dout, want);
			tick(2);
			// preloaded latches stay off the pins
			check_out(outs, {4'h5, 5'h11, 2'h2, 2'h1, 2'h1, 2'h1});
		end
		sample_sel = 1'h0;
		extest_sel = 1'h1;
		clock_enable_sys = 5'h00;
		tick(5);
		check_out(outs, from_latch(LATCH_A));
		scan_tester_inst.scan(LATCH_B, dout);
		tick(5);
		check_out(outs, from_latch(LATCH_B));
		rstn = 1'h0;
		tick(2);
		check_out(outs, 17'h0000c);
		rstn = 1'h1;
		tick(5);
		check_out(outs, from_latch('0));
		tally_and_finish();
	end
endmodule

// ===== bench/scan_tester.sv
// tester model that drives the test clock, serial data and tap state levels
`timescale 1ns/1ps
module scan_tester #(
	parameter int LEN = 24
)(
	input  logic tdo,        // serial out of the chain
	output logic tck,        // test clock, still between frames
	output logic tdi,        // serial in
	output logic capture_dr, // capture state level
	output logic shift_dr,   // shift state level
	output logic update_dr   // update state level
);
	initial
	begin
		tck        = 1'h0;
		tdi        = 1'h0;
		capture_dr = 1'h0;
		shift_dr   = 1'h0;
		update_dr  = 1'h0;
	end

	// one 145 ns test clock period, levels move 20 ns after the fall
	task automatic pulse();
		#62.5 tck = 1'h1;
		#62.5 tck = 1'h0;
		#20;
	endtask

	// capture, shift din in while collecting dout, then update
	task automatic scan(input logic [LEN-1:0] din, output logic [LEN-1:0] dout);
		capture_dr = 1'h1;
		pulse();
		capture_dr = 1'h0;
		shift_dr = 1'h1;
		for (int i = 0; i < LEN; i++)
		begin
			tdi = din[i];
			dout[i] = tdo;
			pulse();
		end
		shift_dr = 1'h0;
		tdi = ~tdi; // released line does not keep its level
		update_dr = 1'h1;
		pulse();
		update_dr = 1'h0;
	endtask
endmodule

// ===== hdl/boundary_scan_chain.sv
// boundary scan cells for port pins, reset pin, clock options and comparator
`timescale 1ns/1ps
module boundary_scan_chain #(
	parameter int N_PINS = 8
)(
	input  logic                         mclk,                     // system clock, 200 MHz
	input  logic                         rstn,                     // async reset, active low
	input  logic                         tck,                      // test clock pin
	input  logic                         tdi,                      // test data in pin
	output logic                         tdo,                      // test data out
	input  logic                         capture_dr,               // tap in capture state
	input  logic                         shift_dr,                 // tap in shift state
	input  logic                         update_dr,                // tap in update state
	input  logic                         extest_sel,               // external test instruction loaded
	input  logic                         sample_sel,               // sample/preload instruction loaded
	input  logic                         global_pullup_disable,    // system pull-up disable
	input  logic [N_PINS-1:0]            pin_output_register,      // system port output bits
	input  logic [N_PINS-1:0]            pin_direction_bit,        // system direction bits
	input  logic [N_PINS-1:0]            pin_in,                   // pad input level
	output logic [N_PINS-1:0]            pin_out,                  // pad output level
	output logic [N_PINS-1:0]            pin_oe_n,                 // pad drive, low drives
	output logic [N_PINS-1:0]            pin_pullup_enable,        // pad pull-up on
	input  logic [1:0]                   two_wire_sys_enable,      // system two-wire enable
	output logic [1:0]                   two_wire_driver_enable,   // slew-limited driver on
	input  logic                         normal_reset_n_pin,       // normal reset pin level
	input  logic                         hv_program_reset,         // high-voltage reset detect
	input  logic [scan_pkg::CLK_NUM-1:0] clock_enable_sys,         // system clock option enables
	input  logic [scan_pkg::CLK_NUM-1:0] clock_line,               // raw clock option outputs
	output logic [scan_pkg::CLK_NUM-1:0] clock_enable_out,         // enables to oscillators
	input  logic                         comparator_off_sys,       // system comparator off
	input  logic                         comparator_mux_sys,       // system mux select
	input  logic                         comparator_bg_sys,        // system bandgap select
	input  logic                         comparator_result,        // analog comparator output
	output logic                         comparator_off,           // to comparator
	output logic                         comparator_mux_select,    // to comparator
	output logic                         comparator_bandgap_select,// to comparator
	output logic                         comparator_neg_from_mux   // negative input from adc mux
);

	localparam int LEN = scan_pkg::PIN_BASE + scan_pkg::PIN_CELLS * N_PINS;
	localparam int SW  = N_PINS + scan_pkg::SYNC_FIXED;

	if (N_PINS < scan_pkg::TWI_NUM)
	begin : pins_check
		$error("need at least two port pins for the two-wire cells");
	end

	// ****************************************
	// helpers
	// ****************************************

	function automatic int pin_pos(input int p, input int k);
		pin_pos = scan_pkg::PIN_BASE + scan_pkg::PIN_CELLS * p + k;
	endfunction

	function automatic int clk_pos(input int c, input int obs);
		clk_pos = scan_pkg::CLK_BASE + 2 * c + obs;
	endfunction

	// ****************************************
	// input synchronisers
	// ****************************************

	logic [SW-1:0] meta_reg;
	logic [SW-1:0] sync_reg;

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			meta_reg <= '0;
			sync_reg <= '0;
		end
		else
		begin
			meta_reg <= {tck, tdi, capture_dr, shift_dr, update_dr, extest_sel, sample_sel, pin_in,
				normal_reset_n_pin, hv_program_reset, clock_line, comparator_result};
			sync_reg <= meta_reg;
		end
	end

	logic                         tck_s;
	logic                         tdi_s;
	logic                         cap_s;
	logic                         shift_s;
	logic                         upd_s;
	logic                         ext_s;
	logic                         sample_s;
	logic [N_PINS-1:0]            pin_in_s;
	logic                         rst_normal_s;
	logic                         rst_hv_s;
	logic [scan_pkg::CLK_NUM-1:0] clk_line_s;
	logic                         cmp_res_s;

	assign {tck_s, tdi_s, cap_s, shift_s, upd_s, ext_s, sample_s, pin_in_s,
		rst_normal_s, rst_hv_s, clk_line_s, cmp_res_s} = sync_reg;

	// ****************************************
	// test clock edges
	// ****************************************

	logic tck_prev_reg;
	logic tck_rise;
	logic tck_fall;

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			tck_prev_reg <= 1'h0;
		else
			tck_prev_reg <= tck_s;
	end

	assign tck_rise = tck_s & ~tck_prev_reg;
	assign tck_fall = ~tck_s & tck_prev_reg;

	// ****************************************
	// system side values and capture vector
	// ****************************************

	logic [N_PINS-1:0]            pue_sys;
	logic [scan_pkg::CLK_NUM-1:0] clk_obs;
	logic [LEN-1:0]               cap_vec;
	logic [LEN-1:0]               latch;

	// R3 pull-up expression
	assign pue_sys = ~{N_PINS{global_pullup_disable}} & ~pin_direction_bit & pin_output_register;

	// R14 idle clock levels
	always_comb
	begin
		for (int c = 0; c < scan_pkg::CLK_NUM; c++)
			clk_obs[c] = clock_enable_out[c] ? clk_line_s[c] : scan_pkg::CLK_IDLE[c];
	end

	always_comb
	begin
		cap_vec = '0;
		// R9 reset observe cells
		cap_vec[scan_pkg::RST_NORMAL_POS] = rst_normal_s;
		cap_vec[scan_pkg::RST_HV_POS]     = rst_hv_s;
		// R12 R18 internal options unscanned
		// R13 five clock pairs
		for (int c = 0; c < scan_pkg::CLK_NUM; c++)
		begin
			cap_vec[clk_pos(c, 0)] = clock_enable_sys[c];
			cap_vec[clk_pos(c, 1)] = clk_obs[c];
		end
		// R19 comparator cells
		cap_vec[scan_pkg::CMP_BASE + scan_pkg::CMP_OFF] = comparator_off_sys;
		cap_vec[scan_pkg::CMP_BASE + scan_pkg::CMP_MUX] = comparator_mux_sys;
		cap_vec[scan_pkg::CMP_BASE + scan_pkg::CMP_BG]  = comparator_bg_sys;
		cap_vec[scan_pkg::CMP_BASE + scan_pkg::CMP_RES] = cmp_res_s;
		// R7 no spike filter cell
		// R6 two-wire enable cells
		for (int t = 0; t < scan_pkg::TWI_NUM; t++)
			cap_vec[scan_pkg::TWI_BASE + t] = two_wire_sys_enable[t];
		// R1 R4 pin data cells capture the pad itself, pull-up and control cells capture the system values
		for (int p = 0; p < N_PINS; p++)
		begin
			cap_vec[pin_pos(p, scan_pkg::PIN_PUE)]  = pue_sys[p];
			cap_vec[pin_pos(p, scan_pkg::PIN_OC)]   = pin_direction_bit[p];
			cap_vec[pin_pos(p, scan_pkg::PIN_DATA)] = pin_in_s[p];
		end
	end

	// ****************************************
	// shift chain
	// ****************************************

	// R25 fixed layout
	scan_shift_chain #(
		.LEN (LEN)
	) u_chain (
		.mclk        (mclk),
		.rstn        (rstn),
		.tck_rise    (tck_rise),
		.tck_fall    (tck_fall),
		.tdi         (tdi_s),
		.capture     (cap_s),
		.shift       (shift_s),
		.update      (upd_s),
		.capture_vec (cap_vec),
		.latch_vec   (latch),
		.tdo         (tdo)
	);

	// ****************************************
	// port pins
	// ****************************************

	// R22 R23 latches reach pins only under external test
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			pin_out           <= {N_PINS{scan_pkg::PIN_RESET_LEVEL}};
			pin_oe_n          <= '1;
			pin_pullup_enable <= {N_PINS{scan_pkg::PIN_RESET_LEVEL}};
		end
		else
		begin
			for (int p = 0; p < N_PINS; p++)
			begin
				// R2 normal mapping
				pin_out[p]           <= ext_s ? latch[pin_pos(p, scan_pkg::PIN_DATA)] : pin_output_register[p];
				pin_oe_n[p]          <= ext_s ? ~latch[pin_pos(p, scan_pkg::PIN_OC)] : ~pin_direction_bit[p];
				pin_pullup_enable[p] <= ext_s ? latch[pin_pos(p, scan_pkg::PIN_PUE)] : pue_sys[p];
			end
		end
	end

	// R6 two-wire drivers, filter has no cell
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			two_wire_driver_enable <= '0;
		else
		begin
			for (int t = 0; t < scan_pkg::TWI_NUM; t++)
				two_wire_driver_enable[t] <= ext_s ? latch[scan_pkg::TWI_BASE + t] : two_wire_sys_enable[t];
		end
	end

	// ****************************************
	// clock options
	// ****************************************

	// R10 R11 R17 controllable enables
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			clock_enable_out <= '0;
		else
		begin
			for (int c = 0; c < scan_pkg::CLK_NUM; c++)
				clock_enable_out[c] <= ext_s ? latch[clk_pos(c, 0)] : clock_enable_sys[c];
		end
	end

	// ****************************************
	// analog comparator boundary
	// ****************************************

	// R5 R19 digital side of the comparator
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			comparator_off            <= 1'h0;
			comparator_mux_select     <= 1'h0;
			comparator_bandgap_select <= 1'h0;
		end
		else
		begin
			comparator_off            <= ext_s ? latch[scan_pkg::CMP_BASE + scan_pkg::CMP_OFF] : comparator_off_sys;
			comparator_mux_select     <= ext_s ? latch[scan_pkg::CMP_BASE + scan_pkg::CMP_MUX] : comparator_mux_sys;
			comparator_bandgap_select <= ext_s ? latch[scan_pkg::CMP_BASE + scan_pkg::CMP_BG] : comparator_bg_sys;
		end
	end

	// R20 negative input source
	assign comparator_neg_from_mux = comparator_mux_select;

	// ****************************************
	// checks
	// ****************************************

	pullup_expr_a: assert property (@(posedge mclk) disable iff (!rstn) // R3
		!ext_s |=> pin_pullup_enable == $past(~{N_PINS{global_pullup_disable}} & ~pin_direction_bit
			& pin_output_register))
		else $error("pull-up enable does not follow its expression");

	normal_map_a: assert property (@(posedge mclk) disable iff (!rstn) // R2
		!ext_s |=> (pin_out == $past(pin_output_register)) && (pin_oe_n == ~$past(pin_direction_bit)))
		else $error("pins do not follow the port registers");

	extest_drive_a: assert property (@(posedge mclk) disable iff (!rstn) // R22
		ext_s |=> (pin_out[0] == $past(latch[scan_pkg::PIN_BASE + scan_pkg::PIN_DATA]))
			&& (pin_oe_n[0] == ~$past(latch[scan_pkg::PIN_BASE + scan_pkg::PIN_OC])))
		else $error("latched value not driven under external test");

	sample_apart_a: assert property (@(posedge mclk) disable iff (!rstn) // R23
		(sample_s && !ext_s) ##1 (!ext_s && $changed(latch)) |-> pin_out == $past(pin_output_register))
		else $error("latches reached the pins under sample");

	pin_capture_a: assert property (@(posedge mclk) disable iff (!rstn) // R4
		(tck_rise && cap_s) |=> u_chain.shift_reg[scan_pkg::PIN_BASE + scan_pkg::PIN_DATA] == $past(pin_in_s[0]))
		else $error("pin cell did not capture the pad level");

	reset_obs_a: assert property (@(posedge mclk) disable iff (!rstn) // R9
		(tck_rise && cap_s) |=> (u_chain.shift_reg[scan_pkg::RST_NORMAL_POS] == $past(rst_normal_s))
			&& (u_chain.shift_reg[scan_pkg::RST_HV_POS] == $past(rst_hv_s)))
		else $error("reset observe cells wrong");

	clock_idle_a: assert property (@(posedge mclk) disable iff (!rstn) // R14
		!clock_enable_out[scan_pkg::CLK_EXT_RC] && !clock_enable_out[scan_pkg::CLK_EXT]
			|-> clk_obs[scan_pkg::CLK_EXT_RC] && !clk_obs[scan_pkg::CLK_EXT])
		else $error("unused clock line reads wrong level");

	clock_ovr_a: assert property (@(posedge mclk) disable iff (!rstn) // R17
		ext_s ##1 ext_s |-> clock_enable_out == $past({latch[10], latch[8], latch[6], latch[4], latch[2]}))
		else $error("clock enable not taken from the chain");

	twi_enable_a: assert property (@(posedge mclk) disable iff (!rstn) // R6
		ext_s |=> two_wire_driver_enable == $past(latch[scan_pkg::TWI_BASE + 1 : scan_pkg::TWI_BASE]))
		else $error("two-wire enable not taken from the chain");

	cmp_mux_a: assert property (@(posedge mclk) disable iff (!rstn) // R20
		ext_s ##1 ext_s |-> comparator_neg_from_mux == $past(latch[scan_pkg::CMP_BASE + scan_pkg::CMP_MUX]))
		else $error("comparator mux select not from the chain");

	sys_follow_a: assert property (@(posedge mclk) disable iff (!rstn) // R2
		!ext_s |=> (two_wire_driver_enable == $past(two_wire_sys_enable))
			&& (clock_enable_out == $past(clock_enable_sys)))
		else $error("enables do not follow the system side");

	cmp_drive_a: assert property (@(posedge mclk) disable iff (!rstn) // R19
		ext_s |=> (comparator_off == $past(latch[scan_pkg::CMP_BASE + scan_pkg::CMP_OFF]))
			&& (comparator_bandgap_select == $past(latch[scan_pkg::CMP_BASE + scan_pkg::CMP_BG])))
		else $error("comparator inputs not taken from the chain");

	pullup_drive_a: assert property (@(posedge mclk) disable iff (!rstn) // R1
		ext_s |=> pin_pullup_enable[0] == $past(latch[scan_pkg::PIN_BASE + scan_pkg::PIN_PUE]))
		else $error("pull-up not taken from the chain");

	clock_capture_a: assert property (@(posedge mclk) disable iff (!rstn) // R13
		(tck_rise && cap_s) |=> (u_chain.shift_reg[clk_pos(scan_pkg::CLK_EXT_RC, 1)]
			== $past(clk_obs[scan_pkg::CLK_EXT_RC])))
		else $error("observed clock line not captured");

	cmp_capture_a: assert property (@(posedge mclk) disable iff (!rstn) // R19
		(tck_rise && cap_s) |=> u_chain.shift_reg[scan_pkg::CMP_BASE + scan_pkg::CMP_RES] == $past(cmp_res_s))
		else $error("comparator result not captured");

	twi_capture_a: assert property (@(posedge mclk) disable iff (!rstn) // R6
		(tck_rise && cap_s) |=> u_chain.shift_reg[scan_pkg::TWI_BASE + 1] == $past(two_wire_sys_enable[1]))
		else $error("two-wire enable not captured");

	oc_capture_a: assert property (@(posedge mclk) disable iff (!rstn) // R2
		(tck_rise && cap_s) |=> u_chain.shift_reg[scan_pkg::PIN_BASE + scan_pkg::PIN_OC] == $past(pin_direction_bit[0]))
		else $error("output control cell did not capture direction");

endmodule

// ===== hdl/scan_shift_chain.sv
// serial capture, shift and update stages of the scan chain
`timescale 1ns/1ps
module scan_shift_chain #(
	parameter int LEN = 32
)(
	input  logic           mclk,        // system clock
	input  logic           rstn,        // async reset, active low
	input  logic           tck_rise,    // one-cycle pulse on test clock rise
	input  logic           tck_fall,    // one-cycle pulse on test clock fall
	input  logic           tdi,         // synchronised serial in
	input  logic           capture,     // capture state level
	input  logic           shift,       // shift state level
	input  logic           update,      // update state level
	input  logic [LEN-1:0] capture_vec, // parallel values to capture
	output logic [LEN-1:0] latch_vec,   // update latches
	output logic           tdo          // serial out
);

	logic [LEN-1:0] shift_reg;

	if (LEN < 2)
	begin : len_check
		$error("scan chain too short");
	end

	// R24 lsb first
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			shift_reg <= '0;
		else if (tck_rise && capture)
			shift_reg <= capture_vec;
		else if (tck_rise && shift)
			shift_reg <= {tdi, shift_reg[LEN-1:1]};
	end

	// R23 update loads latches
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			latch_vec <= '0;
		else if (tck_fall && update)
			latch_vec <= shift_reg;
	end

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			tdo <= 1'h0;
		else
			tdo <= shift_reg[0];
	end

	shift_order_a: assert property (@(posedge mclk) disable iff (!rstn) // R24
		(tck_rise && shift && !capture) |=> (shift_reg[LEN-1] == $past(tdi)) && (shift_reg[0] == $past(shift_reg[1])))
		else $error("chain did not shift lsb first");

	update_load_a: assert property (@(posedge mclk) disable iff (!rstn) // R23
		(tck_fall && update) |=> (latch_vec == $past(shift_reg)))
		else $error("update did not load latches");

endmodule

// ===== shared/scan_pkg.sv
// constants for the boundary scan chain of the port, reset, clock and comparator cells
//
// Behaviour
// R1 - each port pin has a pull-up cell and a two-stage control/data pin cell
// R2 - idle pin cells mirror input pin, output register and direction register
// R3 - pull-up enable is not global disable, and not direction, and output register
// R4 - pin cells capture the real external pin level, not alternate function values
// R5 - analog pins bypass the chain; cells sit on the digital/analog boundary signals
// R6 - both two-wire pins carry an extra general cell on the two-wire driver enable
// R7 - the two-wire input spike filter has no cell of its own
// R8 - tester never sets output control and two-wire enable together on one pin
// R9 - reset pin has observe cells for normal reset and high-voltage programming reset
// R10 - each external oscillator has a controllable enable cell and an observe cell
// R11 - timer oscillator is scanned with the same enable and observe pair
// R12 - the internal RC oscillator output is not in the chain
// R13 - five pairs: external clock, crystal, external RC, low-frequency crystal, timer
// R14 - unused clock lines read 0, except external RC which reads 1
// R15 - tester enables at most one main clock source at a time
// R16 - tester prefers scanning an external clock over an oscillator output
// R17 - oscillator enables are scan-controllable to override sleep-mode logic
// R18 - internal capacitor configuration is not in the chain
// R19 - comparator off, bandgap select, mux select and result each have a cell
// R20 - when mux select is true the negative input takes the converter mux
// R21 - comparator cells need not be exercised for connectivity testing
// R22 - under external test the latched values drive the pins at once
// R23 - under sample/preload the update loads latches that stay off the pins
// R24 - the chain shifts least significant bit in and out first
// R25 - cell order along the chain is one fixed layout given below
package scan_pkg;

	// chain layout, bit 0 is nearest the serial output
	localparam int RST_NORMAL_POS = 0;
	localparam int RST_HV_POS     = 1;
	localparam int CLK_NUM        = 5;
	localparam int CLK_BASE       = 2;
	localparam int CMP_BASE       = 12;
	localparam int CMP_OFF        = 0;
	localparam int CMP_MUX        = 1;
	localparam int CMP_BG         = 2;
	localparam int CMP_RES        = 3;
	localparam int TWI_NUM        = 2;
	localparam int TWI_BASE       = 16;
	localparam int PIN_BASE       = 18;
	localparam int PIN_CELLS      = 3;
	localparam int PIN_PUE        = 0;
	localparam int PIN_OC         = 1;
	localparam int PIN_DATA       = 2;

	// clock option index within the clock vectors
	localparam int CLK_EXT        = 0;
	localparam int CLK_CRYSTAL    = 1;
	localparam int CLK_EXT_RC     = 2;
	localparam int CLK_LOWFREQ    = 3;
	localparam int CLK_TIMER      = 4;

	// level an unused observed clock line reads, one bit per option
	localparam logic [CLK_NUM-1:0] CLK_IDLE = 5'h04;

	// async inputs other than pins passing the synchroniser
	localparam int SYNC_FIXED     = 15;

	// pin data out and pull-up after reset, pins released
	localparam logic PIN_RESET_LEVEL = 1'h0;

endpackage
